// ---- core/frame_header_indicator_framer_map.vh ----
// Register map, field positions and frame layout constants of the header framer.
// Assumes a 32-bit APB bus with 8-bit byte addresses and one protocol clock.
//
// Behaviour
// - Send header, then payload, then trailer.
// - Fields go left to right; reserved first.
// - Five-byte header in fixed field order.
// - Transmitted reserved bit always zero.
// - Received reserved bit accepted either way.
// - Received reserved bit kept for frame check.
// - Vector flag one: payload starts with vector.
// - Vector flag zero: no vector in payload.
// - Null frame sends zero bytes, vector flag cleared.
// - Null frame payload marked unusable on receive.
// - Timebase flag zero: excluded from synchronisation.
// - Timebase flag one: used if otherwise accepted.
// - Null timebase frames still give arrival time.
// - Coldstart flag only with timebase flag set.
// - Timebase frames only in static segment.
// - Coldstart flag necessary, not sufficient, on receive.
// - Slot identifier 11 bits, MSB first, zero invalid.
// - Length field 7 bits, half byte count.
// - Check header code, preset value, over 20 bits.
// - Cycle number 6 bits, MSB first, last.
`ifndef FRAME_HEADER_INDICATOR_FRAMER_MAP_VH
`define FRAME_HEADER_INDICATOR_FRAMER_MAP_VH

// ==========================================================
// Register offsets
`define REG_CTRL        8'h00
`define REG_TXFIELD     8'h04
`define REG_TXCHECK     8'h08
`define REG_COMMAND     8'h0C
`define REG_STATUS      8'h10
`define REG_RXFIELD     8'h14
`define REG_RXCHECK     8'h18

// ==========================================================
// Control fields
`define CTRL_VECTOR     0
`define CTRL_VALID      1
`define CTRL_TIMEBASE   2
`define CTRL_COLDSTART  3
`define CTRL_DYNAMIC    4
`define CTRL_WIDTH      5
`define CTRL_RESET      5'h02

// ==========================================================
// Field positions inside the transmit and receive field and check words
`define SLOT_LSB        0
`define SLOT_MSB        10
`define LEN_LSB         16
`define LEN_MSB         22
`define CHECK_LSB       0
`define CHECK_MSB       10
`define CYCLE_LSB       16
`define CYCLE_MSB       21
`define RXFLAG_LSB      24

// ==========================================================
// Status bits and the command send bit
`define ST_BUSY         0
`define ST_CFGERR       1
`define ST_ORDERERR     2
`define ST_SEGERR       3
`define CMD_SEND        0

// ==========================================================
// Frame layout
`define HDR_BITS        6'd40
`define BYTE_BITS       6'd8
`define TRL_BITS        6'd24
`define CHECK_INIT      11'h01A
`define CHECK_POLY      11'h385
`define CHECK_DATA      20

`endif

// ---- core/frame_header_indicator_framer.v ----
// Header framer: builds and serialises frames, and decodes received headers.
// Assumes the bit encoder and decoder run on the same clock and hand bits
// one at a time, valid/ready on the transmit side and valid only on receive; trailer code comes from outside.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "frame_header_indicator_framer_map.vh"

module frame_header_indicator_framer
#(
   parameter SLOT_W  = 11,
   parameter LEN_W   = 7,
   parameter CHECK_W = 11,
   parameter CYCLE_W = 6
)
(
   input  wire        clock,
   input  wire        reset,
   input  wire        clockEnable,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [7:0]  payByte,
   output reg         payTake,
   input  wire [23:0] trailerCode,
   output wire        txBit,
   output reg         txValid,
   input  wire        txReady,
   output reg         txDone,
   input  wire        rxStart,
   input  wire        rxBit,
   input  wire        rxValid,
   output reg         rxDone,
   output reg         rxReserved,
   output reg         rxPayloadVector,
   output reg         rxPayloadValid,
   output reg         rxTimebase,
   output reg         rxColdstart,
   output reg  [10:0] rxSlot,
   output reg  [6:0]  rxLength,
   output reg  [5:0]  rxCycle,
   output reg         rxCheckOk,
   output reg         rxSyncUse,
   output reg         rxStartupCandidate,
   output reg         rxPayloadUsable
);

   // ==========================================================
   // Transmit states
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_HDR  = 2'b01;
   localparam [1:0] ST_PAY  = 2'b10;
   localparam [1:0] ST_TRL  = 2'b11;

   // ==========================================================
   // Registers
   reg [`CTRL_WIDTH-1:0] ctrl_r;
   reg [SLOT_W-1:0]      txSlot_r;
   reg [LEN_W-1:0]       txLength_r;
   reg [CHECK_W-1:0]     txCheck_r;
   reg [CYCLE_W-1:0]     txCycle_r;
   reg                   cfgErr_r;
   reg                   segErr_r;
   reg                   orderErr_r;
   reg [1:0]             state_r;
   reg [39:0]            shift_r;
   reg [5:0]             bitCnt_r;
   reg [7:0]             byteCnt_r;
   reg                   txNull_r;
   reg [39:0]            rxShift_r;
   reg [5:0]             rxCnt_r;
   reg [CHECK_W-1:0]     rxCheck_r;

   wire apbAccess = psel & penable & pready;
   wire apbWrite  = apbAccess & pwrite;
   wire bitTaken  = txValid & txReady;
   wire lastBit   = (bitCnt_r == 6'd0);

   // ==========================================================
   // Header check code over timebase, coldstart, slot and length
   function [10:0] headerCheck;
      input [19:0] data;
      integer      i;
      reg   [10:0] crc;
      begin
         crc = `CHECK_INIT;
         for (i = `CHECK_DATA - 1; i >= 0; i = i - 1)
            crc = {crc[9:0], 1'b0} ^ ((data[i] ^ crc[10]) ? `CHECK_POLY : 11'h000);
         headerCheck = crc;
      end
   endfunction

   // ==========================================================
   // Send request checks
   wire sendReq       = apbWrite & (paddr == `REG_COMMAND) & pwdata[`CMD_SEND];
   wire wantTimebase  = ctrl_r[`CTRL_TIMEBASE];
   wire wantColdstart = ctrl_r[`CTRL_COLDSTART];
   wire wantValid     = ctrl_r[`CTRL_VALID];
   wire badPairing    = wantColdstart & ~wantTimebase;
   wire badSegment    = wantTimebase & ctrl_r[`CTRL_DYNAMIC];
   wire busy          = (state_r != ST_IDLE);
   wire sendOk        = sendReq & ~busy & ~badPairing & ~badSegment;
   wire refuse        = sendReq & ~busy;
   wire stClear       = apbWrite & (paddr == `REG_STATUS);
   // Null frame forces the vector flag low; reserved bit is a constant zero
   wire        txVectorBit = ctrl_r[`CTRL_VECTOR] & wantValid;
   wire [39:0] txHeader    = {1'b0,
                              txVectorBit, wantValid,
                              wantTimebase, wantColdstart,
                              txSlot_r,
                              txLength_r,
                              txCheck_r,
                              txCycle_r};
   wire [7:0]  nextByte    = txNull_r ? 8'h00 : payByte;
   wire        hasPayload  = (txLength_r != {LEN_W{1'b0}});

   // ==========================================================
   // APB registers and flags
   always @(posedge clock)
   begin
      if (reset)
      begin
         ctrl_r     <= `CTRL_RESET;
         txSlot_r   <= {SLOT_W{1'b0}};
         txLength_r <= {LEN_W{1'b0}};
         txCheck_r  <= {CHECK_W{1'b0}};
         txCycle_r  <= {CYCLE_W{1'b0}};
         cfgErr_r   <= 1'b0;
         segErr_r   <= 1'b0;
         orderErr_r <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (apbWrite & ~busy)
         begin
            // Frame fields are frozen while a frame is on the wire
            case (paddr)
               `REG_CTRL:
               begin
                  ctrl_r <= pwdata[`CTRL_WIDTH-1:0];
               end
               `REG_TXFIELD:
               begin
                  txSlot_r   <= pwdata[`SLOT_MSB:`SLOT_LSB];
                  txLength_r <= pwdata[`LEN_MSB:`LEN_LSB];
               end
               `REG_TXCHECK:
               begin
                  txCheck_r <= pwdata[`CHECK_MSB:`CHECK_LSB];
                  txCycle_r <= pwdata[`CYCLE_MSB:`CYCLE_LSB];
               end
               default:
               begin
               end
            endcase
         end
         // Writing one clears a flag; a new refusal in the same cycle wins
         cfgErr_r   <= (cfgErr_r & ~(stClear & pwdata[`ST_CFGERR])) | (refuse & (badPairing | badSegment));
         orderErr_r <= (orderErr_r & ~(stClear & pwdata[`ST_ORDERERR])) | (refuse & badPairing);
         segErr_r   <= (segErr_r & ~(stClear & pwdata[`ST_SEGERR])) | (refuse & badSegment);
      end
   end

   // ==========================================================
   // APB answer: one wait state, error on unmapped offsets
   reg [31:0] readMux;
   reg        mapped;
   always @*
   begin
      readMux = 32'h0000_0000;
      mapped  = 1'b1;
      case (paddr)
         `REG_CTRL:
         begin
            readMux[`CTRL_WIDTH-1:0] = ctrl_r;
         end
         `REG_TXFIELD:
         begin
            readMux[`SLOT_MSB:`SLOT_LSB] = txSlot_r;
            readMux[`LEN_MSB:`LEN_LSB]   = txLength_r;
         end
         `REG_TXCHECK:
         begin
            readMux[`CHECK_MSB:`CHECK_LSB] = txCheck_r;
            readMux[`CYCLE_MSB:`CYCLE_LSB] = txCycle_r;
         end
         `REG_STATUS:
         begin
            readMux[`ST_BUSY]     = busy;
            readMux[`ST_CFGERR]   = cfgErr_r;
            readMux[`ST_ORDERERR] = orderErr_r;
            readMux[`ST_SEGERR]   = segErr_r;
         end
         `REG_RXFIELD:
         begin
            readMux[`SLOT_MSB:`SLOT_LSB] = rxSlot;
            readMux[`LEN_MSB:`LEN_LSB]   = rxLength;
            readMux[`RXFLAG_LSB+4:`RXFLAG_LSB] = {rxReserved, rxPayloadVector,
                                                  rxPayloadValid, rxTimebase, rxColdstart};
         end
         `REG_RXCHECK:
         begin
            readMux[`CHECK_MSB:`CHECK_LSB] = rxCheck_r;
            readMux[`CYCLE_MSB:`CYCLE_LSB] = rxCycle;
            readMux[`RXFLAG_LSB+3:`RXFLAG_LSB] = {rxCheckOk, rxSyncUse,
                                                  rxStartupCandidate, rxPayloadUsable};
         end
         default:
         begin
            mapped = (paddr == `REG_COMMAND);                           // Command word reads as zero
         end
      endcase
   end

   always @(posedge clock)
   begin
      if (reset)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (clockEnable)
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? readMux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Transmit serialiser: header, payload bytes, trailer
   assign txBit = shift_r[39];
   always @(posedge clock)
   begin
      if (reset)
      begin
         state_r   <= ST_IDLE;
         shift_r   <= 40'h00_0000_0000;
         bitCnt_r  <= 6'd0;
         byteCnt_r <= 8'h00;
         txNull_r  <= 1'b0;
         txValid   <= 1'b0;
         txDone    <= 1'b0;
         payTake   <= 1'b0;
      end
      else if (clockEnable)
      begin
         txDone  <= 1'b0;
         payTake <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               if (sendOk)
               begin
                  shift_r   <= txHeader;
                  bitCnt_r  <= `HDR_BITS - 6'd1;
                  byteCnt_r <= {txLength_r, 1'b0};
                  txNull_r  <= ~wantValid;
                  txValid   <= 1'b1;
                  state_r   <= ST_HDR;
               end
            end
            ST_HDR, ST_PAY, ST_TRL:
            begin
               if (bitTaken & ~lastBit)
               begin
                  shift_r  <= {shift_r[38:0], 1'b0};
                  bitCnt_r <= bitCnt_r - 6'd1;
               end
               else if (bitTaken & (state_r == ST_TRL))
               begin
                  txValid <= 1'b0;
                  txDone  <= 1'b1;
                  state_r <= ST_IDLE;
               end
               else if (bitTaken & ((state_r == ST_HDR) ? hasPayload : (byteCnt_r != 8'h00)))
               begin
                  // Next payload byte; the source sees one take pulse per byte
                  shift_r   <= {nextByte, 32'h0000_0000};
                  bitCnt_r  <= `BYTE_BITS - 6'd1;
                  byteCnt_r <= byteCnt_r - 8'h01;
                  payTake   <= 1'b1;
                  state_r   <= ST_PAY;
               end
               else if (bitTaken)
               begin
                  shift_r  <= {trailerCode, 16'h0000};
                  bitCnt_r <= `TRL_BITS - 6'd1;
                  state_r  <= ST_TRL;
               end
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Receive header decoder
   // The reserved bit stays in the shifted word so the frame check sees it
   wire [39:0] rxWord   = {rxShift_r[38:0], rxBit};
   wire        rxLast   = rxValid & (rxCnt_r == `HDR_BITS - 6'd1);
   wire [10:0] rxCalc   = headerCheck(rxWord[36:17]);
   wire        rxGood   = (rxCalc == rxWord[16:6]);
   wire        rxSlotOk = (rxWord[34:24] != 11'h000);

   always @(posedge clock)
   begin
      if (reset)
      begin
         rxShift_r          <= 40'h00_0000_0000;
         rxCnt_r            <= 6'd0;
         rxCheck_r          <= {CHECK_W{1'b0}};
         rxDone             <= 1'b0;
         rxReserved         <= 1'b0;
         rxPayloadVector    <= 1'b0;
         rxPayloadValid     <= 1'b0;
         rxTimebase         <= 1'b0;
         rxColdstart        <= 1'b0;
         rxSlot             <= 11'h000;
         rxLength           <= 7'h00;
         rxCycle            <= 6'h00;
         rxCheckOk          <= 1'b0;
         rxSyncUse          <= 1'b0;
         rxStartupCandidate <= 1'b0;
         rxPayloadUsable    <= 1'b0;
      end
      else if (clockEnable)
      begin
         rxDone <= 1'b0;
         if (rxStart)
         begin
            rxCnt_r <= 6'd0;
         end
         else if (rxValid & (rxCnt_r < `HDR_BITS))
         begin
            rxShift_r <= rxWord;
            rxCnt_r   <= rxCnt_r + 6'd1;
         end
         if (~rxStart & rxLast)
         begin
            rxDone          <= 1'b1;
            rxReserved      <= rxWord[39];
            rxPayloadVector <= rxWord[38];
            rxPayloadValid  <= rxWord[37];
            rxTimebase      <= rxWord[36];
            rxColdstart     <= rxWord[35];
            rxSlot          <= rxWord[34:24];
            rxLength        <= rxWord[23:17];
            rxCheck_r       <= rxWord[16:6];
            rxCycle         <= rxWord[5:0];
            rxCheckOk       <= rxGood;
            // Null frames still feed timing when all else is accepted
            rxSyncUse       <= rxWord[36] & rxGood & rxSlotOk;
            // Only a hint: startup logic applies its own further checks
            rxStartupCandidate <= rxWord[35] & rxWord[36] & rxGood & rxSlotOk;
            rxPayloadUsable <= rxWord[37] & rxGood & rxSlotOk;
         end
      end
   end

endmodule
`default_nettype wire

// ---- verification/frame_header_indicator_framer_monitor.sv ----
// Port checker for the header framer, attached by bind.
// Assumes one clock domain; state is frozen while clockEnable is low.
`timescale 1ns/1ps
`default_nettype none
module frame_header_indicator_framer_monitor
(
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        clockEnable,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        payTake,
   input wire logic        txBit,
   input wire logic        txValid,
   input wire logic        txReady,
   input wire logic        txDone,
   input wire logic        rxDone,
   input wire logic        rxPayloadValid,
   input wire logic        rxTimebase,
   input wire logic        rxColdstart,
   input wire logic [10:0] rxSlot,
   input wire logic        rxCheckOk,
   input wire logic        rxSyncUse,
   input wire logic        rxStartupCandidate,
   input wire logic        rxPayloadUsable
);
   // ==========================================
   // Transmit bit position tracking
   logic [11:0] bitCnt_r;
   logic        vecBit_r;
   logic        tbBit_r;
   wire logic   take = txValid & txReady & clockEnable;
   always_ff @(posedge clock)
   begin
      if (reset || !txValid)
         bitCnt_r <= 12'h000;
      else if (take)
         bitCnt_r <= bitCnt_r + 12'h001;
      if (take && bitCnt_r == 12'h001)
         vecBit_r <= txBit;
      if (take && bitCnt_r == 12'h003)
         tbBit_r <= txBit;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset || !clockEnable);
   // ==========================================
   // Assertions
   AST_PREADY_WAIT: assert property ($rose(penable) && psel |=> pready)
      else $error("pready not one cycle after access start");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_RESERVED_LOW: assert property ($rose(txValid) |-> !txBit)
      else $error("first header bit not zero");
   AST_NULL_VECTOR: assert property (take && bitCnt_r == 12'h002 && !txBit |-> !vecBit_r)
      else $error("vector flag sent in null frame");
   AST_COLDSTART_SYNC: assert property (take && bitCnt_r == 12'h004 && txBit |-> tbBit_r)
      else $error("coldstart flag sent without timebase flag");
   AST_PAYLOAD_AFTER_HEADER: assert property (payTake |-> bitCnt_r >= 12'h028 && bitCnt_r[2:0] == 3'h0)
      else $error("payload byte loaded off a byte boundary after header");
   AST_DONE_END: assert property ($fell(txValid) |-> txDone ##1 !txDone)
      else $error("txDone not a single pulse at frame end");
   AST_SYNC_QUAL: assert property (rxDone |-> rxSyncUse == (rxTimebase && rxCheckOk && rxSlot != 11'h000))
      else $error("sync use flag wrong");
   AST_STARTUP_QUAL: assert property (rxDone |-> rxStartupCandidate == (rxColdstart && rxSyncUse))
      else $error("startup candidate flag wrong");
   AST_PAYLOAD_USE: assert property (rxDone |-> rxPayloadUsable == (rxPayloadValid && rxCheckOk && |rxSlot))
      else $error("payload usable flag wrong");
   AST_RXDONE_PULSE: assert property (rxDone |=> !rxDone)
      else $error("rxDone longer than one cycle");
   cover property (txDone);
   cover property (rxDone && rxSyncUse);
   cover property (rxDone && rxStartupCandidate);
endmodule
bind frame_header_indicator_framer frame_header_indicator_framer_monitor u_monitor
(
   .clock, .reset, .clockEnable, .psel, .penable, .pready, .payTake, .txBit, .txValid, .txReady,
   .txDone, .rxDone, .rxPayloadValid, .rxTimebase, .rxColdstart, .rxSlot, .rxCheckOk, .rxSyncUse,
   .rxStartupCandidate, .rxPayloadUsable
);
`default_nettype wire

// ---- verification/remote_node_model.sv ----
// Far-side model: bit encoder taking transmit bits, bit decoder feeding headers.
// Assumes the framer's clock; the bench calls sendHeader to feed the receiver.
`timescale 1ns/1ps
`default_nettype none
module remote_node_model
(
   input wire logic  clock,
   input wire logic  reset,
   input wire logic  slow,
   input wire logic  txBit,
   input wire logic  txValid,
   output var logic  txReady,
   output var logic  rxStart,
   output var logic  rxBit,
   output var logic  rxValid
);
   // ==========================================
   // Transmit side: slow mode stalls half the time
   logic [1:0] tick_r;
   logic       txSeen[$];
   initial
   begin
      tick_r = 2'h0;
      txReady = 1'b0;
      rxStart = 1'b0;
      rxBit = 1'b0;
      rxValid = 1'b0;
   end
   always @(posedge clock)
   begin
      tick_r <= tick_r + 2'h1;
      txReady <= !reset && (!slow || tick_r[1]);
      if (txValid && txReady)
         txSeen.push_back(txBit);
   end
   // ==========================================
   // Receive side: idle line shows the inverse of the last bit
   task automatic sendHeader(input logic [39:0] hdr);
      integer i;
      @(posedge clock);
      rxStart <= 1'b1;
      for (i = 39; i >= 0; i--)
      begin
         @(posedge clock);
         rxStart <= 1'b0;
         rxValid <= 1'b1;
         rxBit <= hdr[i];
      end
      @(posedge clock);
      rxValid <= 1'b0;
      rxBit <= !hdr[0];
   endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench: register access, frame transmit and header receive.
// Assumes the framer map header on the include path and the far-side model.
`timescale 1ns/1ps
`default_nettype none
`include "frame_header_indicator_framer_map.vh"
module testbench;
   logic        clock, reset, clockEnable, psel, penable, pwrite, pready, pslverr, payTake, slow;
   logic        txBit, txValid, txReady, txDone, rxStart, rxBit, rxValid, rxDone, rxReserved;
   logic        rxPayloadVector, rxPayloadValid, rxTimebase, rxColdstart, rxCheckOk, rxSyncUse;
   logic        rxStartupCandidate, rxPayloadUsable;
   logic [7:0]  paddr, payByte;
   logic [31:0] pwdata, prdata;
   logic [23:0] trailerCode;
   logic [10:0] rxSlot;
   logic [6:0]  rxLength;
   logic [5:0]  rxCycle;
   integer      err_total, comparisons;
   frame_header_indicator_framer u_dut
   (
      .clock, .reset, .clockEnable, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .payByte, .payTake, .trailerCode, .txBit, .txValid, .txReady, .txDone, .rxStart,
      .rxBit, .rxValid, .rxDone, .rxReserved, .rxPayloadVector, .rxPayloadValid, .rxTimebase,
      .rxColdstart, .rxSlot, .rxLength, .rxCycle, .rxCheckOk, .rxSyncUse, .rxStartupCandidate,
      .rxPayloadUsable
   );
   remote_node_model u_node
   (
      .clock, .reset, .slow, .txBit, .txValid, .txReady, .rxStart, .rxBit, .rxValid
   );
   // ==========================================
   // Shared tasks and expectation functions
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock)
      if (payTake)
         payByte <= payByte + 8'h3B;
   task automatic print_verdict(input integer extra);
      err_total = err_total + extra;
      $display("Comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Master holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      integer n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 20)
            print_verdict(1);
         @(posedge clock);
      end
      q = prdata;
      check("pslverr", a > 8'h18, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [10:0] hdrCrc(input logic [19:0] d);
      logic [10:0] r;
      r = `CHECK_INIT;
      for (int i = 19; i >= 0; i--)
         r = {r[9:0], 1'b0} ^ ((d[i] ^ r[10]) ? `CHECK_POLY : 11'h000);
      return r;
   endfunction
   // ==========================================
   // Main sequence
   initial
   begin
      logic [31:0] q;
      logic [4:0]  ctl;
      logic [10:0] slot, chk;
      logic [6:0]  len;
      logic [5:0]  cyc;
      logic [7:0]  pb, b;
      logic [23:0] tc;
      logic [39:0] h;
      logic        ok, usable;
      logic        exp[$];
      integer      k, n;
      err_total = 0;
      comparisons = 0;
      {psel, penable, pwrite, paddr, pwdata, slow, trailerCode} = '0;
      clockEnable = 1'b1;
      payByte = 8'h5C;
      reset = 1'b1;
      void'($urandom(32'h4c23));
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, `REG_CTRL, 32'h0000_0000, q);
      check("ctrl reset", 32'h0000_0002, q);
      apb(1'b0, `REG_STATUS, 32'h0000_0000, q);
      check("status reset", 32'h0000_0000, q);
      apb(1'b0, 8'h1C, 32'h0000_0000, q);
      check("unmapped data", 32'h0000_0000, q);
      // Transmit: null, coldstart without timebase, timebase in dynamic, coldstart sync, random
      for (k = 0; k < 14; k++)
      begin
         ctl = k == 0 ? 5'h05 : k == 1 ? 5'h08 : k == 2 ? 5'h14 : k == 3 ? 5'h0E : 5'($urandom);
         {slot, chk, cyc, tc} = {$urandom, $urandom};
         len = 7'($urandom_range(0, 3));
         slow <= k[0];
         trailerCode <= tc;
         apb(1'b1, `REG_CTRL, {27'h000_0000, ctl}, q);
         apb(1'b1, `REG_TXFIELD, {9'h000, len, 5'h00, slot}, q);
         apb(1'b1, `REG_TXCHECK, {10'h000, cyc, 5'h00, chk}, q);
         u_node.txSeen.delete();
         pb = payByte;
         apb(1'b1, `REG_COMMAND, 32'h0000_0001, q);
         if ((ctl[3] && !ctl[2]) || (ctl[2] && ctl[4]))
         begin
            repeat (5) @(posedge clock);
            check("refused txValid", 0, txValid);
            apb(1'b0, `REG_STATUS, 32'h0000_0000, q);
            check("status flags", {ctl[2] & ctl[4], ctl[3] & !ctl[2]}, q[3:2]);
            apb(1'b1, `REG_STATUS, 32'h0000_000E, q);
            apb(1'b0, `REG_STATUS, 32'h0000_0000, q);
            check("status cleared", 0, q[3:1]);
         end
         else
         begin
            for (n = 0; txDone !== 1'b1; n++)
            begin
               if (n > 4000)
                  print_verdict(1);
               @(posedge clock);
            end
            exp = {};
            h = {1'b0, ctl[0] & ctl[1], ctl[1], ctl[2], ctl[3], slot, len, chk, cyc};
            for (n = 39; n >= 0; n--)
               exp.push_back(h[n]);
            for (n = 0; n < 16 * len; n++)
            begin
               b = ctl[1] ? pb + 8'h3B * 8'(n / 8) : 8'h00;
               exp.push_back(b[7 - n % 8]);
            end
            for (n = 23; n >= 0; n--)
               exp.push_back(tc[n]);
            check("tx bit count", exp.size(), u_node.txSeen.size());
            ok = exp.size() == u_node.txSeen.size();
            foreach (exp[i])
               if (ok && exp[i] !== u_node.txSeen[i])
                  ok = 1'b0;
            check("tx stream", 1, ok);
         end
      end
      // Receive: slot zero, reserved bit set with a good code, then random headers
      for (k = 0; k < 12; k++)
      begin
         ctl = 5'($urandom);
         ctl[4] = k == 1 ? 1'b1 : ctl[4];
         {slot, cyc, chk} = $urandom;
         slot = k == 0 ? 11'h000 : slot;
         len = 7'($urandom);
         chk = k[1] ? chk : hdrCrc({ctl[1:0], slot, len});
         u_node.sendHeader({ctl, slot, len, chk, cyc});
         for (n = 0; rxDone !== 1'b1; n++)
         begin
            if (n > 10)
               print_verdict(1);
            @(posedge clock);
         end
         ok = chk == hdrCrc({ctl[1:0], slot, len});
         usable = ok && slot != 11'h000;
         h = {ctl, slot, len, cyc};
         check("rx fields", h, {rxReserved, rxPayloadVector, rxPayloadValid, rxTimebase, rxColdstart,
            rxSlot, rxLength, rxCycle});
         check("rx qualifiers", {ok, ctl[1] & usable, ctl[0] & ctl[1] & usable, ctl[2] & usable},
            {rxCheckOk, rxSyncUse, rxStartupCandidate, rxPayloadUsable});
         apb(1'b0, `REG_RXFIELD, 32'h0000_0000, q);
         check("rxfield reg", {3'h0, ctl, 1'b0, len, 5'h00, slot}, q);
         apb(1'b0, `REG_RXCHECK, 32'h0000_0000, q);
         check("rxcheck reg", {4'h0, ok, ctl[1] & usable, ctl[0] & ctl[1] & usable, ctl[2] & usable,
            2'h0, cyc, 5'h00, chk}, q);
      end
      print_verdict(0);
   end
endmodule
`default_nettype wire
